// ---- inc/updown_converter_numerics_pkg.sv ----
// Constants, types and helpers for the up/down converter numeric datapath.
// Assumes a single 100 MHz system clock and one sample per accept.
package updown_converter_numerics_pkg;

  // ==========================================================================
  // Sample widths
  localparam int IN_W_DEF  = 16;
  localparam int IN_W_MIN  = 11;
  localparam int IN_W_MAX  = 17;
  localparam int OUT_W_DEF = 16;
  localparam int OUT_W_MIN = 11;
  localparam int OUT_W_MAX = 18;
  localparam int HEAD_BITS = 1;   // Integer headroom bit at input
  localparam int CAR_BITS  = 1;   // Growth from summing two carriers

  // ==========================================================================
  // Filter: four taps, 1-3-3-1 over 8 for unity DC gain
  localparam int TAPS      = 4;
  localparam int FIR_SHIFT = 3;
  localparam int HIST_LAT  = TAPS; // Impulse response length in samples

  // ==========================================================================
  // Oscillator raster
  localparam int MIX_RATE_KHZ = 30720;
  localparam int LTE_STD_KHZ  = 200;
  localparam int TDS_STD_KHZ  = 100;
  localparam int PH_W         = 11;
  localparam int LUT_N        = 16;
  localparam int LUT_W        = 8;
  localparam int LUT_SHIFT    = 6;

  // Greatest common divisor, evaluated at elaboration
  function automatic int gcd(input int a, input int b);
    int x;
    int y;
    int t;
    x = a;
    y = b;
    while (y != 0) begin
      t = x % y;
      x = y;
      y = t;
    end
    return x;
  endfunction : gcd

  localparam int RASTER_LTE_KHZ = gcd(MIX_RATE_KHZ, LTE_STD_KHZ);
  localparam int RASTER_TDS_KHZ = gcd(MIX_RATE_KHZ, TDS_STD_KHZ);
  localparam logic [PH_W-1:0] MOD_LTE =
    PH_W'(MIX_RATE_KHZ / RASTER_LTE_KHZ);
  localparam logic [PH_W-1:0] MOD_TDS =
    PH_W'(MIX_RATE_KHZ / RASTER_TDS_KHZ);
  localparam logic [PH_W-1:0] DIV_LTE = PH_W'(MOD_LTE / LUT_N);
  localparam logic [PH_W-1:0] DIV_TDS = PH_W'(MOD_TDS / LUT_N);

  typedef enum logic [1:0] {
    SLOT_FIRST = 2'b01,
    SLOT_LAST  = 2'b10
  } slot_e;

  // Cosine table, 16 points, scaled by 64
  function automatic logic signed [LUT_W-1:0] cosLut(input logic [3:0] k);
    case (k)
      4'h0:    return 8'h40;
      4'h1:    return 8'h3B;
      4'h2:    return 8'h2D;
      4'h3:    return 8'h18;
      4'h4:    return 8'h00;
      4'h5:    return 8'hE8;
      4'h6:    return 8'hD3;
      4'h7:    return 8'hC5;
      4'h8:    return 8'hC0;
      4'h9:    return 8'hC5;
      4'hA:    return 8'hD3;
      4'hB:    return 8'hE8;
      4'hC:    return 8'h00;
      4'hD:    return 8'h18;
      4'hE:    return 8'h2D;
      default: return 8'h3B;
    endcase
  endfunction : cosLut

  // Advance a phase by a signed raster index, modulo m
  function automatic logic [PH_W-1:0] phStep(input logic [PH_W-1:0] ph,
      input logic signed [PH_W:0] f, input logic [PH_W-1:0] m);
    logic [PH_W:0] inc;
    logic [PH_W:0] s;
    inc = f[PH_W] ? (PH_W+1)'(f + $signed({1'b0, m})) : (PH_W+1)'(f);
    s = {1'b0, ph} + inc;
    if (s >= {1'b0, m}) s = s - {1'b0, m};
    return s[PH_W-1:0];
  endfunction : phStep

endpackage : updown_converter_numerics_pkg

// ---- hdl/sat_symmetric.sv ----
// Symmetric saturation: replaces the most negative code by its neighbour.
// Assumes a combinational context; en comes from a static mode bit.
`timescale 1ns/1ps
module sat_symmetric
  import updown_converter_numerics_pkg::*;
#(
  parameter int W = IN_W_DEF
) (
  input  wire logic         en,   // Saturation enabled
  input  wire logic [W-1:0] din,  // Raw sample
  output logic      [W-1:0] dout  // Saturated sample
);

  localparam logic [W-1:0] MOST_NEG = {1'b1, {(W-1){1'b0}}};
  localparam logic [W-1:0] NEG_LIM  = {1'b1, {(W-2){1'b0}}, 1'b1};

  // ==========================================================================
  // Clamp
  assign dout = (en && din == MOST_NEG) ? NEG_LIM : din;

endmodule : sat_symmetric

// ---- hdl/round_convergent.sv ----
// Round-half-to-even of a signed word, dropping D low bits, then wrapping
// to OW bits. Assumes D >= 1 and OW <= W - D.
`timescale 1ns/1ps
module round_convergent
  import updown_converter_numerics_pkg::*;
#(
  parameter int W  = 8,
  parameter int D  = 2,
  parameter int OW = 6
) (
  input  wire logic [W-1:0]  din,  // Full precision value
  output logic      [OW-1:0] dout  // Rounded, wrapped value
);

  logic [W-D-1:0] kept;
  logic           rest;
  logic           up;
  logic [W-D-1:0] sum;

  // ==========================================================================
  // Sticky bits below the half position
  generate
    if (D > 1) begin : g_rest
      assign rest = |din[D-2:0];
    end else begin : g_norest
      assign rest = 1'b0;
    end
  endgenerate

  // Ties go to the even neighbour
  assign kept = din[W-1:D];
  assign up   = din[D-1] & (rest | kept[0]);
  assign sum  = kept + (W-D)'(up);
  assign dout = sum[OW-1:0];

endmodule : round_convergent

// ---- hdl/updown_converter_numerics.sv ----
// Numeric datapath of a two-carrier converter: symmetric input saturation,
// headroom, FIR with persistent history, rasterised or quarter-rate mixing,
// carrier summation and output rounding. One clock, one sample per accept.
// Assumes the source presents carriers in order and holds mode inputs.
`timescale 1ns/1ps

// Summary of operation
// - Input samples are signed fractions of IN_W bits, minus one to below one.
// - In quarter rate mode the most negative input code is saturated.
// - Every filter and carrier phasor mixer result is rounded half to even; the quarter rate mixer does not round.
// - Internal overflow wraps in two's complement, never saturates.
// - One headroom integer bit is added at input; filter gain is unity.
// - Carrier summation adds a further integer bit.
// - Oscillator phase steps only in whole raster steps.
// - Raster step is gcd of mixer rate and 200 or 100 kHz standard raster, 40 or 20 kHz.
// - Filter sample history is never cleared.
// - Output is consistent only after latency-many known samples flush.
// - A settled flag marks when history no longer holds unknowns.
// - Datapath reset leaves the filter history untouched.
// - Input width is a build parameter from 11 to 17 bits.
// - Output width is a build parameter from 11 to 18 bits.
module updown_converter_numerics
  import updown_converter_numerics_pkg::*;
#(
  parameter int IN_W  = IN_W_DEF,
  parameter int OUT_W = OUT_W_DEF
) (
  input  wire logic                   clk_sys,            // System clock
  input  wire logic                   nrst,               // Datapath reset
  input  wire logic                   inValid,            // Sample offered
  output logic                        inReady,            // Sample taken
  input  wire logic [IN_W-1:0]        inI,                // In-phase in
  input  wire logic [IN_W-1:0]        inQ,                // Quadrature in
  input  wire logic                   quarterRateIfMode,  // Fixed Fs/4 mix
  input  wire logic                   stdTdScdma,         // 100 kHz raster
  input  wire logic signed [PH_W:0]   carrierFreq0,       // Raster index
  input  wire logic signed [PH_W:0]   carrierFreq1,       // Raster index
  output logic                        outValid,           // Sample ready
  input  wire logic                   outReady,           // Sink takes it
  output logic [OUT_W-1:0]            outI,               // In-phase out
  output logic [OUT_W-1:0]            outQ,               // Quadrature out
  output logic                        historySettledFlag  // History clean
);

  localparam int HW = IN_W + HEAD_BITS;   // After headroom
  localparam int FW = HW + FIR_SHIFT;     // Filter accumulator
  localparam int PW = HW + LUT_W + 1;     // Mixer products summed
  localparam int MW = HW + CAR_BITS;      // Carrier sum
  localparam int CW = $clog2(HIST_LAT + 1);
  localparam logic [CW-1:0] LAT = CW'(HIST_LAT);

  // ==========================================================================
  // State
  slot_e                  slot_q, slot_d;
  logic [1:0]             rot_q, rot_d;
  logic [PH_W-1:0]        phase_q [2];
  logic [PH_W-1:0]        phase_d [2];
  logic [MW-1:0]          acc_q [2];
  logic [MW-1:0]          acc_d [2];
  logic                   outValid_q, outValid_d;
  logic [OUT_W-1:0]       outI_q, outI_d, outQ_q, outQ_d;
  logic [CW-1:0]          cnt_q, cnt_d;
  logic                   settled_q, settled_d;
  logic [HW-1:0]          hist [2][TAPS-1];

  logic                   accept;
  logic [IN_W-1:0]        inLane [2];
  logic [IN_W-1:0]        satLane [2];
  logic [HW-1:0]          headLane [2];
  logic [FW-1:0]          firSum [2];
  logic [HW-1:0]          firOut [2];
  logic [PW-1:0]          mixSum [2];
  logic [HW-1:0]          mixOut [2];
  logic [HW-1:0]          qMix [2];
  logic [MW-1:0]          outPre [2];
  logic [OUT_W-1:0]       outRnd [2];
  logic                   car;
  logic [PH_W-1:0]        modulus;
  logic [3:0]             lutIdx;
  logic signed [LUT_W-1:0] cosV, sinV;

  // ==========================================================================
  // Handshake; nothing is taken while reset is held
  assign accept  = inValid && inReady;
  assign inReady = nrst && (!outValid_q || outReady);
  assign inLane[0] = inI;
  assign inLane[1] = inQ;

  // ==========================================================================
  // Oscillator: pick carrier phase, map raster phase onto the table
  assign car     = (slot_q == SLOT_LAST);
  assign modulus = stdTdScdma ? MOD_TDS : MOD_LTE;
  assign lutIdx  = stdTdScdma ? 4'(phase_q[car] / DIV_TDS)
                              : 4'(phase_q[car] / DIV_LTE);
  assign cosV    = cosLut(lutIdx);
  assign sinV    = cosLut(lutIdx - 4'h4);

  // ==========================================================================
  // Per-lane front end: saturate, headroom, filter, complex mix
  generate
    for (genvar l = 0; l < 2; l++) begin : g_lane
      sat_symmetric #(.W(IN_W)) u_sat (
        .en   (quarterRateIfMode),
        .din  (inLane[l]),
        .dout (satLane[l])
      );
      assign headLane[l] = {satLane[l][IN_W-1], satLane[l]};
      // Taps 1-3-3-1, sum wraps at FW bits
      assign firSum[l] = FW'($signed(headLane[l]))
                       + FW'($signed(hist[l][0])) * FW'(3)
                       + FW'($signed(hist[l][1])) * FW'(3)
                       + FW'($signed(hist[l][2]));
      round_convergent #(.W(FW), .D(FIR_SHIFT), .OW(HW)) u_rfir (
        .din  (firSum[l]),
        .dout (firOut[l])
      );
      round_convergent #(.W(PW), .D(LUT_SHIFT), .OW(HW)) u_rmix (
        .din  (mixSum[l]),
        .dout (mixOut[l])
      );
      if (OUT_W < MW) begin : g_rnd
        round_convergent #(.W(MW), .D(MW-OUT_W), .OW(OUT_W)) u_rout (
          .din  (outPre[l]),
          .dout (outRnd[l])
        );
      end else begin : g_pad
        assign outRnd[l] = {outPre[l], {(OUT_W-MW){1'b0}}};
      end
    end
  endgenerate

  // Complex rotation by the carrier phasor
  assign mixSum[0] = PW'($signed(firOut[0])) * PW'(cosV)
                   - PW'($signed(firOut[1])) * PW'(sinV);
  assign mixSum[1] = PW'($signed(firOut[0])) * PW'(sinV)
                   + PW'($signed(firOut[1])) * PW'(cosV);

  // ==========================================================================
  // Quarter rate mixer: rotate by -j per sample, negating by inversion
  always_comb begin
    case (rot_q)
      2'd0:    begin qMix[0] = firOut[0];  qMix[1] = firOut[1];  end
      2'd1:    begin qMix[0] = firOut[1];  qMix[1] = ~firOut[0]; end
      2'd2:    begin qMix[0] = ~firOut[0]; qMix[1] = ~firOut[1]; end
      default: begin qMix[0] = ~firOut[1]; qMix[1] = firOut[0];  end
    endcase
    for (int l = 0; l < 2; l++) begin
      if (quarterRateIfMode)
        outPre[l] = {qMix[l][HW-1], qMix[l]};
      else
        outPre[l] = acc_q[l] + {mixOut[l][HW-1], mixOut[l]};
    end
  end

  // ==========================================================================
  // Next state: output register, slots, phases, settle counter
  always_comb begin
    slot_d     = slot_q;
    rot_d      = rot_q;
    phase_d    = phase_q;
    acc_d      = acc_q;
    outValid_d = outValid_q;
    outI_d     = outI_q;
    outQ_d     = outQ_q;
    cnt_d      = cnt_q;
    if (outValid_q && outReady) outValid_d = 1'b0;
    if (accept) begin
      if (cnt_q != LAT) cnt_d = cnt_q + CW'(1);
      if (quarterRateIfMode) begin
        rot_d      = rot_q + 2'd1;
        outValid_d = 1'b1;
        outI_d     = outRnd[0];
        outQ_d     = outRnd[1];
      end else begin
        case (slot_q)
          SLOT_FIRST: begin
            acc_d[0] = {mixOut[0][HW-1], mixOut[0]};
            acc_d[1] = {mixOut[1][HW-1], mixOut[1]};
            slot_d   = SLOT_LAST;
          end
          SLOT_LAST: begin
            outValid_d = 1'b1;
            outI_d     = outRnd[0];
            outQ_d     = outRnd[1];
            slot_d     = SLOT_FIRST;
            phase_d[0] = phStep(phase_q[0], carrierFreq0, modulus);
            phase_d[1] = phStep(phase_q[1], carrierFreq1, modulus);
          end
          default: slot_d = SLOT_FIRST;
        endcase
      end
    end
    settled_d = (cnt_d == LAT);
  end

  // ==========================================================================
  // Registers under synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      slot_q     <= SLOT_FIRST;
      rot_q      <= 2'd0;
      phase_q    <= '{default: '0};
      acc_q      <= '{default: '0};
      outValid_q <= 1'b0;
      outI_q     <= '0;
      outQ_q     <= '0;
      cnt_q      <= '0;
      settled_q  <= 1'b0;
    end else begin
      slot_q     <= slot_d;
      rot_q      <= rot_d;
      phase_q    <= phase_d;
      acc_q      <= acc_d;
      outValid_q <= outValid_d;
      outI_q     <= outI_d;
      outQ_q     <= outQ_d;
      cnt_q      <= cnt_d;
      settled_q  <= settled_d;
    end
  end

  // ==========================================================================
  // Filter history: shifts on accept, no reset term at all
  always_ff @(posedge clk_sys) begin
    if (accept) begin
      for (int l = 0; l < 2; l++) begin
        hist[l][0] <= headLane[l];
        hist[l][1] <= hist[l][0];
        hist[l][2] <= hist[l][1];
      end
    end
  end

  assign outValid           = outValid_q;
  assign outI               = outI_q;
  assign outQ               = outQ_q;
  assign historySettledFlag = settled_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_width_range: assert property (IN_W >= IN_W_MIN && IN_W <= IN_W_MAX &&
      OUT_W >= OUT_W_MIN && OUT_W <= OUT_W_MAX)
    else $error("sample width outside the allowed range");
  a_sat_symmetric: assert property (quarterRateIfMode |->
      satLane[0] != {1'b1, {(IN_W-1){1'b0}}})
    else $error("most negative code passed in quarter rate mode");
  a_headroom_sign: assert property (headLane[1][HW-1] == inQ[IN_W-1] &&
      headLane[1][HW-2] == inQ[IN_W-1])
    else $error("headroom bit is not a sign copy");
  a_round_tie_even: assert property ((firSum[0][FIR_SHIFT:0] == 4'b0100)
      |-> firOut[0] == firSum[0][FIR_SHIFT+HW-1:FIR_SHIFT])
    else $error("tie on even value was rounded away");
  a_raster_gcd: assert property (MOD_LTE * RASTER_LTE_KHZ == MIX_RATE_KHZ
      && RASTER_LTE_KHZ <= LTE_STD_KHZ && RASTER_TDS_KHZ <= TDS_STD_KHZ)
    else $error("oscillator raster is not a divisor of the mix rate");
  a_phase_raster: assert property (phase_q[0] < modulus &&
      phase_q[1] < modulus)
    else $error("carrier phase left the raster");
  a_history_kept: assert property (@(posedge clk_sys) disable iff (1'b0)
      !nrst |=> $stable(hist[0][0]) &&
      $stable(hist[1][2]))
    else $error("reset disturbed the filter history");
  a_settle_early: assert property ($past(!nrst) |-> !historySettledFlag
      ##1 !historySettledFlag)
    else $error("history flag settled right after reset");
  a_settle_count: assert property ($rose(historySettledFlag) |->
      $past(cnt_q) == LAT - CW'(1) && $past(accept))
    else $error("history flag settled at the wrong count");
  a_carrier_emit: assert property (accept && !quarterRateIfMode &&
      slot_q == SLOT_LAST |=> outValid && slot_q == SLOT_FIRST)
    else $error("carrier sum not emitted after last carrier");
  a_out_hold: assert property (outValid && !outReady |=>
      outValid && $stable(outI) && $stable(outQ))
    else $error("output sample changed while stalled");

  // Reset, flag and pairing discipline
  a_flag_sticky: assert property (historySettledFlag |=>
      historySettledFlag)
    else $error("history flag dropped without a reset");
  a_reset_quiet: assert property (@(posedge clk_sys)
      disable iff (1'b0) !nrst |=> !outValid && !historySettledFlag)
    else $error("output or flag active right after reset");
  a_ready_in_reset: assert property (@(posedge clk_sys)
      disable iff (1'b0) !nrst |-> !inReady)
    else $error("sample could be taken during reset");
  a_pair_silent: assert property (accept && !quarterRateIfMode &&
      slot_q == SLOT_FIRST && !outValid |=> !outValid)
    else $error("first carrier emitted a sample on its own");
  a_phase_frozen: assert property (!(accept &&
      !quarterRateIfMode && slot_q == SLOT_LAST) |=>
      $stable(phase_q[0]) && $stable(phase_q[1]))
    else $error("carrier phase moved inside a pair");

  c_settled: cover property ($rose(historySettledFlag));
  c_quarter: cover property (accept && quarterRateIfMode ##1 outValid);
  c_two_car: cover property (accept && slot_q == SLOT_LAST ##1 outValid);
  c_stall:   cover property (outValid && !outReady ##1 outReady);
  c_phase_turn: cover property (phase_q[0] != '0);

endmodule : updown_converter_numerics

// ---- tb/stream_sink_model.sv ----
// Downstream sample sink for the converter datapath; may stall.
// Assumes outputs change only just after rising edges of clk_sys.
`timescale 1ns/1ps
module stream_sink_model #(
  parameter int W = 17
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         stall,     // Hold off taking samples
  input  wire logic         outValid,  // Sample offered
  output logic              outReady,  // Sample taken
  input  wire logic [W-1:0] outI,      // In-phase sample
  input  wire logic [W-1:0] outQ       // Quadrature sample
);
  // ==========================================================================
  // Capture
  logic [W-1:0] gotI[$];
  logic [W-1:0] gotQ[$];

  // Ready is simply the inverse of the stall request
  assign outReady = !stall;

  // Keep every sample taken, in order
  always @(posedge clk_sys) begin
    if (outValid && outReady) begin
      gotI.push_back(outI);
      gotQ.push_back(outQ);
    end
  end
endmodule : stream_sink_model

// ---- tb/testbench.sv ----
// Self-checking bench for the converter numerics: source tasks, sink model.
// Assumes IN_W 16 and OUT_W 17, so one bit is rounded off at the output.
`timescale 1ns/1ps
module testbench
  import updown_converter_numerics_pkg::*;
;
  // ==========================================================================
  // Signals
  localparam logic [16:0] SAT_LO = 17'h1C000;  // Saturated code, halved
  localparam logic [16:0] SAT_HI = 17'h03FFF;  // Its inversion, halved
  logic                 clk_sys;
  logic                 nrst;
  logic                 inValid;
  logic [15:0]          inI;
  logic [15:0]          inQ;
  logic                 quarterRateIfMode;
  logic                 stdTdScdma;
  logic signed [PH_W:0] carrierFreq0;
  logic signed [PH_W:0] carrierFreq1;
  logic                 stall;
  logic                 inReady;
  logic                 outValid;
  logic                 outReady;
  logic [16:0]          outI;
  logic [16:0]          outQ;
  logic                 historySettledFlag;
  logic [16:0]          held;
  int                   mismatches;
  int                   total_checks;
  int                   base;

  updown_converter_numerics #(.IN_W(16), .OUT_W(17)) u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .inValid(inValid), .inReady(inReady),
    .inI(inI), .inQ(inQ), .quarterRateIfMode(quarterRateIfMode),
    .stdTdScdma(stdTdScdma), .carrierFreq0(carrierFreq0),
    .carrierFreq1(carrierFreq1), .outValid(outValid), .outReady(outReady),
    .outI(outI), .outQ(outQ), .historySettledFlag(historySettledFlag)
  );

  stream_sink_model #(.W(17)) u_sink (
    .clk_sys(clk_sys), .stall(stall), .outValid(outValid),
    .outReady(outReady), .outI(outI), .outQ(outQ)
  );

  // ==========================================================================
  // Tasks
  // Compare and count
  task automatic check(input string name, input logic [16:0] exp,
      input logic [16:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
      mismatches++;
    end
  endtask : check

  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Reset with static modes set; returns at the release edge
  task automatic reset_dut(input logic q, input logic s);
    nrst              <= 1'b0;
    quarterRateIfMode <= q;
    stdTdScdma        <= s;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
  endtask : reset_dut

  // Offer one sample, hold until taken; lower valid if last
  task automatic send(input logic [15:0] i, input logic [15:0] q,
      input bit last);
    int n;
    inValid <= 1'b1;
    inI     <= i;
    inQ     <= q;
    for (n = 0; n < 50; n++) begin
      #1;
      if (inReady === 1'b1) break;
      @(posedge clk_sys);
    end
    if (n == 50) begin
      mismatches++;
      print_verdict();
    end
    @(posedge clk_sys);
    if (last) inValid <= 1'b0;
  endtask : send

  // Four clean outputs follow the rotation order from some phase
  task automatic check_rotation(input int b);
    logic [16:0] eI [4];
    logic [16:0] eQ [4];
    int          n;
    bit          hit;
    eI  = '{SAT_LO, SAT_LO, SAT_HI, SAT_HI};
    eQ  = '{SAT_LO, SAT_HI, SAT_HI, SAT_LO};
    hit = 0;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      for (int j = 0; j < 4; j++) begin
        if (u_sink.gotI[b+j] === eI[(k+j)%4] &&
            u_sink.gotQ[b+j] === eQ[(k+j)%4]) n++;
      end
      if (n == 4) hit = 1;
    end
    check("rotation of saturated input", 17'h1, 17'(hit));
  endtask : check_rotation

  // ==========================================================================
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    nrst              = 1'b0;
    inValid           = 1'b0;
    inI               = 16'h0000;
    inQ               = 16'h0000;
    quarterRateIfMode = 1'b1;
    stdTdScdma        = 1'b0;
    carrierFreq0      = '0;
    carrierFreq1      = '0;
    stall             = 1'b0;
    mismatches        = 0;
    total_checks      = 0;
    @(posedge clk_sys);
    reset_dut(1'b1, 1'b0);
    // Quarter mode: most negative code, flag timing
    for (int k = 0; k < 8; k++) begin
      send(16'h8000, 16'h8000, 1'b1);
      #1;
      check("settled flag", 17'(k >= 3), 17'(historySettledFlag));
      @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
    check("quarter count", 17'h8, 17'(u_sink.gotI.size()));
    check_rotation(4);
    // Sink stalls: output stands, input refused
    stall <= 1'b1;
    send(16'h8000, 16'h8000, 1'b1);
    #1;
    held = outI;
    repeat (3) begin
      @(posedge clk_sys);
      #1;
      check("valid held", 17'h1, 17'(outValid));
      check("ready refused", 17'h0, 17'(inReady));
      check("output stands", held, outI);
    end
    @(posedge clk_sys);
    stall <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("after stall count", 17'h9, 17'(u_sink.gotI.size()));
    // Reset in mid-run keeps the history
    reset_dut(1'b1, 1'b0);
    #1;
    check("flag after reset", 17'h0, 17'(historySettledFlag));
    @(posedge clk_sys);
    send(16'h8000, 16'h8000, 1'b1);
    repeat (3) @(posedge clk_sys);
    check("history kept I", SAT_LO, u_sink.gotI[9]);
    check("history kept Q", SAT_LO, u_sink.gotQ[9]);
    // Carrier mode, both standards, then a quarter-turn raster carrier
    for (int s = 0; s < 3; s++) begin
      carrierFreq0 <= (s == 2) ? 12'sh0C0 : 12'sh000;
      reset_dut(1'b0, s == 1);
      base = u_sink.gotI.size();
      for (int k = 0; k < 8; k++) begin
        send((s == 1) ? 16'h8000 : 16'h7FFF,
             (s == 1) ? 16'h8000 : 16'h7FFF, k == 7);
      end
      repeat (3) @(posedge clk_sys);
      check("pair count", 17'(base + 4), 17'(u_sink.gotI.size()));
      for (int j = 2; j < 4; j++) begin
        check("carrier sum I", (s == 1) ? 17'h18000 :
              ((s == 2 && j == 2) ? 17'h00000 : 17'h07FFF),
              u_sink.gotI[base+j]);
        check("carrier sum Q", (s == 1) ? 17'h18000 :
              ((s == 2) ? 17'h00000 : 17'h07FFF),
              u_sink.gotQ[base+j]);
      end
    end
    // Ties at the filter stage go to the even neighbour, down on 0.5 and up on 1.5
    carrierFreq0 <= 12'sh000;
    reset_dut(1'b0, 1'b0);
    base = u_sink.gotI.size();
    for (int k = 0; k < 6; k++) begin
      send((k == 4) ? 16'h0004 : 16'h0000,
           (k == 4) ? 16'h0004 : 16'h0000, k == 5);
    end
    repeat (3) @(posedge clk_sys);
    check("tie round I", 17'h00001, u_sink.gotI[base+2]);
    check("tie round Q", 17'h00001, u_sink.gotQ[base+2]);
    print_verdict();
  end
endmodule : testbench
